// *** pkg/wdc_pkg.sv ***
// Purpose: shared constants and types for the watchdog counter block
// Assumes: one 100 MHz clock, asynchronous active-high reset
// Notes:   the 256-cycle reset pulse counts oscillator clock cycles
package wdc_pkg;

  localparam int CNT_W            = 8;
  localparam int CTRL_W           = 8;
  // control/status bit positions
  localparam int WE_BIT           = 4;
  localparam int ON_BIT           = 2;
  localparam int INH_BIT          = 3;
  localparam logic [7:0] CNT_MAX  = 8'hFF;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // reset pulse length in oscillator cycles
  localparam int RST_PULSE_CYC    = 256;
  localparam int PULSE_W          = 9;

  typedef struct packed {
    logic       ctrl_wr;
    logic       cnt_wr;
    logic [7:0] wdata;
  } wdc_wr_t;

  typedef enum logic [1:0] {
    WDC_IDLE,
    WDC_COUNT,
    WDC_RESET
  } wdc_state_t;

endpackage : wdc_pkg

// *** rtl/wdc_pulse.sv ***
// Purpose: fixed-length reset pulse generator
// Assumes: start is a one-cycle strobe
// Notes:   output registered; retrigger while busy is ignored
`timescale 1ns/1ps
`default_nettype none
module wdc_pulse #(
  parameter int LEN = wdc_pkg::RST_PULSE_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output var  logic pulse
);

  logic [wdc_pkg::PULSE_W-1:0] cnt;
  logic [wdc_pkg::PULSE_W-1:0] next_cnt;
  logic                        next_pulse;

  always_comb begin
    next_cnt   = cnt;
    next_pulse = pulse;
    if (pulse) begin
      if (cnt == wdc_pkg::PULSE_W'(LEN - 1)) begin
        next_pulse = 1'b0;
        next_cnt   = '0;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else if (start) begin
      next_pulse = 1'b1;
      next_cnt   = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      pulse <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      pulse <= next_pulse;
    end
  end

endmodule : wdc_pulse
`default_nettype wire

// *** rtl/wdc_top.sv ***
// Purpose: watchdog with writable 8-bit up-counter and reset pulse
// Assumes: writes arrive as one-cycle strobes on the system clock
// Notes:   counting clock is a one-cycle enable from outside
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// What this block does
// - watchdog count is an 8-bit up-counter
// - counting starts when on set, inhibit cleared, write-enable already 1
// - count pulse at FF gives overflow and internal reset
// - internal reset stays high exactly 256 oscillator cycles
// - counter is writable; counting continues from written value
// - written value sets overflow time 1 to 256 count pulses
// - bit 4 of control/status is write-enable gating the on bit (bit 2)
module wdc_top (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        CTRL_WR,
  input  wire logic        CNT_WR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        CNT_EN,
  output var  logic [7:0]  CTRL_STATUS,
  output var  logic [7:0]  COUNT,
  output var  logic        OVERFLOW,
  output var  logic        INT_RESET
);

  ////////////////////////////////////////////////////////////////////
  wdc_pkg::wdc_wr_t    wr;
  wdc_pkg::wdc_state_t state;
  wdc_pkg::wdc_state_t next_state;
  logic                ctrl_write_enable;
  logic                next_ctrl_write_enable;
  logic                count_on_bit;
  logic                next_count_on_bit;
  logic [7:0]          watchdog_count_reg;
  logic [7:0]          next_watchdog_count_reg;
  logic                next_overflow;
  logic                ovf_start;
  logic                rst_pulse;

  assign wr = '{ctrl_wr: CTRL_WR, cnt_wr: CNT_WR, wdata: WDATA};

  ////////////////////////////////////////////////////////////////////
  // control/status register
  always_comb begin
    next_ctrl_write_enable = ctrl_write_enable;
    next_count_on_bit      = count_on_bit;
    if (wr.ctrl_wr) begin
      next_ctrl_write_enable = wr.wdata[wdc_pkg::WE_BIT];
      // enable must already be set; one write cannot do both
      if (ctrl_write_enable && !wr.wdata[wdc_pkg::INH_BIT]) begin
        next_count_on_bit = wr.wdata[wdc_pkg::ON_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter and state
  always_comb begin
    next_state              = state;
    next_watchdog_count_reg = watchdog_count_reg;
    next_overflow           = 1'b0;
    case (state)
      wdc_pkg::WDC_IDLE: begin
        if (next_count_on_bit) begin
          next_state = wdc_pkg::WDC_COUNT;
        end
      end
      wdc_pkg::WDC_COUNT: begin
        if (!next_count_on_bit) begin
          next_state = wdc_pkg::WDC_IDLE;
        end else if (CNT_EN && !wr.cnt_wr) begin
          if (watchdog_count_reg == wdc_pkg::CNT_MAX) begin
            next_overflow = 1'b1;
            next_state    = wdc_pkg::WDC_RESET;
          end
          next_watchdog_count_reg = watchdog_count_reg + 8'h01;
        end
      end
      wdc_pkg::WDC_RESET: begin
        // wait for the pin-level reset to drop, so no count slips in
        if (!rst_pulse && !OVERFLOW && !INT_RESET) begin
          next_state = next_count_on_bit ? wdc_pkg::WDC_COUNT
                                         : wdc_pkg::WDC_IDLE;
        end
      end
      default: next_state = wdc_pkg::WDC_IDLE;
    endcase
    // writes win over counting; time to overflow is 256 minus value
    if (wr.cnt_wr) begin
      next_watchdog_count_reg = wr.wdata;
    end
  end

  assign ovf_start = OVERFLOW;

  wdc_pulse #(
    .LEN (wdc_pkg::RST_PULSE_CYC)
  ) u_pulse (
    .clk   (SYS_CLK),
    .rst   (RST),
    .start (ovf_start),
    .pulse (rst_pulse)
  );

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state              <= wdc_pkg::WDC_IDLE;
      ctrl_write_enable  <= 1'b0;
      count_on_bit       <= 1'b0;
      watchdog_count_reg <= wdc_pkg::CNT_RST;
      OVERFLOW           <= 1'b0;
      CTRL_STATUS        <= wdc_pkg::CTRL_RST;
      COUNT              <= wdc_pkg::CNT_RST;
      INT_RESET          <= 1'b0;
    end else begin
      state              <= next_state;
      ctrl_write_enable  <= next_ctrl_write_enable;
      count_on_bit       <= next_count_on_bit;
      watchdog_count_reg <= next_watchdog_count_reg;
      OVERFLOW           <= next_overflow;
      CTRL_STATUS        <= {3'b000, next_ctrl_write_enable, 1'b0,
                             next_count_on_bit, 2'b00};
      COUNT              <= next_watchdog_count_reg;
      INT_RESET          <= rst_pulse;
    end
  end

endmodule : wdc_top
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: directed bench for wdc_top
// Assumes: 100 MHz clock, reset high 3 cycles
// Notes:   full 256-cycle pulse kept, runs stay short
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       SYS_CLK = 1'b0;
  logic       RST     = 1'b1;
  logic       CTRL_WR = 1'b0;
  logic       CNT_WR  = 1'b0;
  logic       CNT_EN  = 1'b0;
  logic [7:0] WDATA   = 8'h00;
  logic [7:0] CTRL_STATUS, COUNT;
  logic       OVERFLOW, INT_RESET;
  int         errors = 0;
  int         total_checks = 0;
  wdc_top wdc_top_i (.*);
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one write strobe, outputs settled on return
  task automatic wr(input logic c, input logic [7:0] d);
    @(posedge SYS_CLK);
    CTRL_WR <= c;
    CNT_WR  <= !c;
    WDATA   <= d;
    @(posedge SYS_CLK);
    CTRL_WR <= 1'b0;
    CNT_WR  <= 1'b0;
    #1;
  endtask : wr
  task automatic t_ctrl;
    wr(1'b1, 8'h14);
    chk("ctrl_locked", 8'h10, CTRL_STATUS);
    wr(1'b1, 8'h1C);
    chk("ctrl_inhibit", 8'h10, CTRL_STATUS);
    wr(1'b1, 8'h14);
    chk("ctrl_on", 8'h14, CTRL_STATUS);
  endtask : t_ctrl
  // v sets the distance to overflow: 256 - v strobes
  task automatic t_ovf(input logic [7:0] v);
    wr(1'b0, v);
    chk("count_wr", v, COUNT);
    repeat (256 - int'(v)) begin
      @(posedge SYS_CLK);
      CNT_EN <= 1'b1;
    end
    #1;
    chk("ovf_early", 8'h00, 8'(OVERFLOW));
    @(posedge SYS_CLK);
    CNT_EN <= 1'b0;
    #1;
    chk("ovf", 8'h01, 8'(OVERFLOW));
    chk("count_wrap", 8'h00, COUNT);
    @(posedge SYS_CLK);
    #1;
    chk("ovf_off", 8'h00, 8'(OVERFLOW));
    chk("irst_start", 8'h00, 8'(INT_RESET));
    @(posedge SYS_CLK);
    CNT_EN <= 1'b1;
    #1;
    chk("irst_on", 8'h01, 8'(INT_RESET));
    // strobes during the pulse must not move the counter
    repeat (255) @(posedge SYS_CLK);
    CNT_EN <= 1'b0;
    #1;
    chk("irst_end", 8'h01, 8'(INT_RESET));
    chk("count_held", 8'h00, COUNT);
    @(posedge SYS_CLK);
    #1;
    chk("irst_off", 8'h00, 8'(INT_RESET));
  endtask : t_ovf
  // reset in mid-pulse clears all; enable must be written again
  task automatic t_rst;
    wr(1'b0, 8'hFF);
    @(posedge SYS_CLK);
    CNT_EN <= 1'b1;
    @(posedge SYS_CLK);
    CNT_EN <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1;
    chk("irst_mid", 8'h01, 8'(INT_RESET));
    @(posedge SYS_CLK);
    RST <= 1'b1;
    #1;
    chk("rst_irst", 8'h00, 8'(INT_RESET));
    chk("rst_ovf", 8'h00, 8'(OVERFLOW));
    chk("rst_ctrl", 8'h00, CTRL_STATUS);
    chk("rst_count", 8'h00, COUNT);
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    wr(1'b1, 8'h14);
    chk("rst_locked", 8'h10, CTRL_STATUS);
    @(posedge SYS_CLK);
    CNT_EN <= 1'b1;
    @(posedge SYS_CLK);
    CNT_EN <= 1'b0;
    #1;
    chk("idle_count", 8'h00, COUNT);
    wr(1'b1, 8'h14);
    chk("rst_on", 8'h14, CTRL_STATUS);
  endtask : t_rst
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_ctrl();
    t_ovf(8'hFF);
    t_ovf(8'hFD);
    t_rst();
    t_ovf(8'h00);
    complete_run();
  end
  initial begin
    #30000;
    errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// *** testbench/wdc_properties.sv ***
// Purpose: port checks for wdc_top
// Assumes: one clock, RST async active high
// Notes:   bound into wdc_top after the module
`timescale 1ns/1ps
`default_nettype none
module wdc_chk (
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       CTRL_WR,
  input wire logic       CNT_WR,
  input wire logic [7:0] WDATA,
  input wire logic       CNT_EN,
  input wire logic [7:0] CTRL_STATUS,
  input wire logic [7:0] COUNT,
  input wire logic       OVERFLOW,
  input wire logic       INT_RESET
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // counter write wins, so a write cycle is no count
  // a write that clears count-on stops the count in the same cycle
  wire logic stop = CTRL_WR && CTRL_STATUS[4] && !WDATA[3] && !WDATA[2];
  wire logic go = CNT_EN && !CNT_WR && !stop && CTRL_STATUS[2] && !INT_RESET;
  sequence s_hi; INT_RESET throughout ##255 1'b1; endsequence
  property p_ovf; go && COUNT == 8'hFF |=> OVERFLOW; endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow");
  property p_cause; OVERFLOW |-> $past(CNT_EN) && $past(COUNT) == 8'hFF;
  endproperty
  a_cause: assert property (p_cause) else $error("bad overflow");
  // both cycles after overflow belong to the pulse start
  property p_inc; go && !OVERFLOW && !$past(OVERFLOW)
    |=> COUNT == $past(COUNT) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("bad count");
  property p_wr; CNT_WR |=> COUNT == $past(WDATA); endproperty
  a_wr: assert property (p_wr) else $error("bad count write");
  property p_lock; CTRL_WR && !CTRL_STATUS[4] |=> $stable(CTRL_STATUS[2]);
  endproperty
  a_lock: assert property (p_lock) else $error("on while locked");
  property p_inh; CTRL_WR && WDATA[3] |=> $stable(CTRL_STATUS[2]);
  endproperty
  a_inh: assert property (p_inh) else $error("on with inhibit");
  property p_start; CTRL_WR && CTRL_STATUS[4] && WDATA[2] && !WDATA[3]
    |=> CTRL_STATUS[2]; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_rst; $rose(OVERFLOW) |-> ##1 !INT_RESET ##1 s_hi ##1 !INT_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset pulse");
endmodule : wdc_chk
bind wdc_top wdc_chk wdc_chk_i (.*);
`default_nettype wire
